//--- usfc_defs.svh
// Register offsets, field positions and reset values of the status flag clear logic.
`ifndef USFC_DEFS_SVH
`define USFC_DEFS_SVH
`define USFC_OFS_FLAG_CLEAR 8'h20
`define USFC_OFS_RECEIVE_DATA 8'h24
`define USFC_OFS_LINE_STATUS 8'h1C
`define USFC_OFS_IRQ_ENABLE 8'h30
`define USFC_OFS_CONTROL 8'h34
`define USFC_OFS_TRANSMIT_DATA 8'h28
`define USFC_OFS_COMMAND 8'h38
`define USFC_B_PARITY 0
`define USFC_B_FRAMING 1
`define USFC_B_NOISE 2
`define USFC_B_OVERRUN 3
`define USFC_B_IDLE 4
`define USFC_B_RXNE 5
`define USFC_B_TC 6
`define USFC_B_TBE 7
`define USFC_B_LIN 8
`define USFC_B_CTS 9
`define USFC_B_CTS_LEVEL 10
`define USFC_B_RTO 11
`define USFC_B_EOB 12
`define USFC_B_ADDR 17
`define USFC_B_WAKE 20
`define USFC_B_ERR_IE 10
`define USFC_B_CTL_MULTIBUF 0
`define USFC_B_CTL_PARITY 1
`define USFC_B_CTL_NINE 2
`define USFC_B_CMD_TXFLUSH 0
`define USFC_B_CMD_RXFLUSH 1
`define USFC_STATUS_RESET 32'h0000_0080
`define USFC_IRQ_SOURCES 32'h0012_1BF1
`define USFC_CTL_RESET 32'h0000_0000
`define USFC_DATA_W 9
`endif

//--- usfc_pkg.sv
// Types shared by the status flag clear logic.
package usfc_pkg;
  typedef struct packed {
    logic rx_load;
    logic [8:0] rx_word;
    logic tx_load;
    logic tx_frame_done;
    logic lin_break;
    logic idle_line;
    logic noise;
    logic framing;
    logic parity;
    logic sc_retry_exhausted;
    logic wakeup;
    logic addr_match;
    logic end_of_block;
    logic rx_timeout;
  } usfc_event_s;
  typedef enum logic [1:0] {
    USFC_IDLE = 2'b00,
    USFC_ACK = 2'b01
  } usfc_bus_e;
endpackage

//--- usfc_remote.sv
// Model of the remote serial device that raises line events and moves the clear-to-send pin.
`timescale 1ns/100ps
module usfc_remote (
  input wire logic mclk,
  output usfc_pkg::usfc_event_s events,
  output logic clear_to_send_pin
);
  initial begin
    events = '0;
    clear_to_send_pin = 1'b1;
  end
  // One-cycle pulse, then a spare edge so that two pulses never merge.
  task automatic send(input usfc_pkg::usfc_event_s ev);
    events <= ev;
    @(posedge mclk);
    events <= '0;
    @(posedge mclk);
  endtask
  task automatic toggle_cts();
    clear_to_send_pin <= ~clear_to_send_pin;
    @(posedge mclk);
    @(posedge mclk);
  endtask
endmodule

//--- usfc_status.sv
// Status flags, flag clear register and receive data register of the serial transceiver.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "usfc_defs.svh"
// Overview of operation
// - CTS pin toggle sets cts change flag; write one to bit 9 clears it.
// - LIN break sets its flag; write one to bit 8 clears it.
// - Transmit empty bit 7 set on shift load or flush; transmit write clears.
// - Transmission complete set when data frame ends with empty set; bit 6 clears.
// - Receive not empty bit 5 set on load; data read or flush clears.
// - Idle flag bit 4 set on idle; rearmed only after receive not empty sets.
// - Overrun set when word loads while receive not empty; bit 3 clears.
// - Noise flag set on noisy frame; bit 2 clears.
// - Framing flag set on desync, noise or break; bit 1 clears.
// - Smartcard transmit retries exhausted also sets the framing flag.
// - Parity flag set on receive parity error; bit 0 clears.
// - Each enabled flag except overrun, noise, framing and CTS level raises the interrupt; receive enable also covers overrun.
// - In multibuffer mode error enable routes overrun, noise, framing to interrupt.
// - Bits 20, 17, 12, 11 clear wakeup, address, end of block, timeout.
// - Reduced instance reserves wakeup, block, timeout, LIN clear bits and LIN flag.
// - Receive data sits in bits 8:0 with parity in top data bit.
module usfc_status #(
  parameter bit REDUCED = 1'b0,
  parameter int DATA_W = `USFC_DATA_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic clear_to_send_pin,
  input wire usfc_pkg::usfc_event_s events,
  output logic tx_data_write,
  output logic [8:0] tx_data,
  output logic [2:0] control_bits,
  output logic irq
);
  // The transmit and receive ports carry one character of the fixed width only.
  if (DATA_W != `USFC_DATA_W) begin : g_width_check
    $error("usfc_status: DATA_W must equal the character width");
  end
  // ==========================================================================
  // Reset and bus handshake
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  usfc_pkg::usfc_bus_e bus_state;
  logic req;
  logic acc;
  logic wr;
  logic rd;
  assign req = avs_read | avs_write;
  // One wait cycle lets every access commit on a single, well defined edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= usfc_pkg::USFC_IDLE;
    end else begin
      case (bus_state)
        usfc_pkg::USFC_IDLE: begin
          if (req) begin
            bus_state <= usfc_pkg::USFC_ACK;
          end
        end
        usfc_pkg::USFC_ACK: bus_state <= usfc_pkg::USFC_IDLE;
        default: bus_state <= usfc_pkg::USFC_IDLE;
      endcase
    end
  end
  assign acc = bus_state == usfc_pkg::USFC_ACK;
  assign avs_waitrequest = req & ~acc;
  assign wr = acc & avs_write;
  assign rd = acc & avs_read;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction
  logic [31:0] wmask;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  logic [31:0] clr;
  // A clear acts only where a one is written; zeros leave flags alone.
  assign clr = (wr && hit(avs_address, `USFC_OFS_FLAG_CLEAR)) ? (avs_writedata & wmask)
             : 32'h0000_0000;
  logic rx_read;
  assign rx_read = rd && hit(avs_address, `USFC_OFS_RECEIVE_DATA);
  logic [31:0] cmd;
  assign cmd = (wr && hit(avs_address, `USFC_OFS_COMMAND)) ? avs_writedata : 32'h0000_0000;
  // ==========================================================================
  // Control and enable registers
  logic [31:0] irq_enable;
  logic [31:0] control;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= `USFC_CTL_RESET;
      control <= `USFC_CTL_RESET;
    end else begin
      if (wr && hit(avs_address, `USFC_OFS_IRQ_ENABLE)) begin
        irq_enable <= (irq_enable & ~wmask) | (avs_writedata & wmask);
      end
      if (wr && hit(avs_address, `USFC_OFS_CONTROL)) begin
        control <= (control & ~wmask) | (avs_writedata & wmask);
      end
    end
  end
  assign control_bits = control[`USFC_B_CTL_NINE:0];
  // ==========================================================================
  // Transmit data path hand-off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_write <= 1'b0;
      tx_data <= 9'h000;
    end else begin
      tx_data_write <= wr && hit(avs_address, `USFC_OFS_TRANSMIT_DATA);
      if (wr && hit(avs_address, `USFC_OFS_TRANSMIT_DATA)) begin
        tx_data <= avs_writedata[`USFC_DATA_W - 1:0];
      end
    end
  end
  // ==========================================================================
  // Status flags; a set always wins over a clear in the same cycle.
  localparam logic [31:0] STATUS_RESET = `USFC_STATUS_RESET;
  logic [31:0] status;
  logic cts_q;
  logic idle_armed;
  logic [DATA_W-1:0] rx_data;
  logic lin_ok;
  logic cts_change_flag;
  logic lin_break_flag;
  logic transmit_empty_flag;
  logic transmission_complete_flag;
  logic receive_not_empty_flag;
  logic idle_line_flag;
  logic overrun_flag;
  logic noise_flag;
  logic framing_flag;
  logic parity_flag;
  logic wakeup_flag;
  logic address_match_flag;
  logic end_of_block_flag;
  logic receiver_timeout_flag;
  logic cts_level;
  assign lin_ok = ~REDUCED;
  // Set wins over clear, so an event that lands with its clear is never lost.
  function automatic logic sticky(input logic set, input logic held, input logic clear);
    sticky = set | (held & ~clear);
  endfunction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cts_q <= 1'b1;
    end else begin
      cts_q <= clear_to_send_pin;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cts_change_flag <= STATUS_RESET[`USFC_B_CTS];
    end else begin
      cts_change_flag <= sticky(cts_q ^ clear_to_send_pin, cts_change_flag,
                                clr[`USFC_B_CTS]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lin_break_flag <= STATUS_RESET[`USFC_B_LIN];
    end else begin
      lin_break_flag <= lin_ok & sticky(events.lin_break, lin_break_flag,
                                        clr[`USFC_B_LIN]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_empty_flag <= STATUS_RESET[`USFC_B_TBE];
    end else begin
      transmit_empty_flag <= sticky(events.tx_load | cmd[`USFC_B_CMD_TXFLUSH],
                                    transmit_empty_flag, tx_data_write);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmission_complete_flag <= STATUS_RESET[`USFC_B_TC];
    end else begin
      transmission_complete_flag <= sticky(events.tx_frame_done & transmit_empty_flag,
                                           transmission_complete_flag,
                                           clr[`USFC_B_TC]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receive_not_empty_flag <= STATUS_RESET[`USFC_B_RXNE];
    end else begin
      receive_not_empty_flag <= sticky(events.rx_load, receive_not_empty_flag,
                                       rx_read | cmd[`USFC_B_CMD_RXFLUSH]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_line_flag <= STATUS_RESET[`USFC_B_IDLE];
    end else begin
      idle_line_flag <= sticky(events.idle_line & idle_armed, idle_line_flag,
                               clr[`USFC_B_IDLE]);
    end
  end
  // A cleared idle flag must not come back until a new character has arrived.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_armed <= 1'b1;
    end else if (events.rx_load) begin
      idle_armed <= 1'b1;
    end else if (events.idle_line && idle_armed) begin
      idle_armed <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_flag <= STATUS_RESET[`USFC_B_OVERRUN];
    end else begin
      overrun_flag <= sticky(events.rx_load & receive_not_empty_flag, overrun_flag,
                             clr[`USFC_B_OVERRUN]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      noise_flag <= STATUS_RESET[`USFC_B_NOISE];
    end else begin
      noise_flag <= sticky(events.noise, noise_flag, clr[`USFC_B_NOISE]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      framing_flag <= STATUS_RESET[`USFC_B_FRAMING];
    end else begin
      framing_flag <= sticky(events.framing | events.sc_retry_exhausted, framing_flag,
                             clr[`USFC_B_FRAMING]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      parity_flag <= STATUS_RESET[`USFC_B_PARITY];
    end else begin
      parity_flag <= sticky(events.parity, parity_flag, clr[`USFC_B_PARITY]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_flag <= STATUS_RESET[`USFC_B_WAKE];
    end else begin
      wakeup_flag <= lin_ok & sticky(events.wakeup, wakeup_flag,
                                     clr[`USFC_B_WAKE]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      address_match_flag <= STATUS_RESET[`USFC_B_ADDR];
    end else begin
      address_match_flag <= sticky(events.addr_match, address_match_flag,
                                   clr[`USFC_B_ADDR]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      end_of_block_flag <= STATUS_RESET[`USFC_B_EOB];
    end else begin
      end_of_block_flag <= lin_ok & sticky(events.end_of_block, end_of_block_flag,
                                           clr[`USFC_B_EOB]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_timeout_flag <= STATUS_RESET[`USFC_B_RTO];
    end else begin
      receiver_timeout_flag <= lin_ok & sticky(events.rx_timeout, receiver_timeout_flag,
                                               clr[`USFC_B_RTO]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cts_level <= STATUS_RESET[`USFC_B_CTS_LEVEL];
    end else begin
      cts_level <= ~clear_to_send_pin;
    end
  end
  // Unused status positions read as zero.
  always_comb begin
    status = 32'h0000_0000;
    status[`USFC_B_CTS] = cts_change_flag;
    status[`USFC_B_LIN] = lin_break_flag;
    status[`USFC_B_TBE] = transmit_empty_flag;
    status[`USFC_B_TC] = transmission_complete_flag;
    status[`USFC_B_RXNE] = receive_not_empty_flag;
    status[`USFC_B_IDLE] = idle_line_flag;
    status[`USFC_B_OVERRUN] = overrun_flag;
    status[`USFC_B_NOISE] = noise_flag;
    status[`USFC_B_FRAMING] = framing_flag;
    status[`USFC_B_PARITY] = parity_flag;
    status[`USFC_B_WAKE] = wakeup_flag;
    status[`USFC_B_ADDR] = address_match_flag;
    status[`USFC_B_EOB] = end_of_block_flag;
    status[`USFC_B_RTO] = receiver_timeout_flag;
    status[`USFC_B_CTS_LEVEL] = cts_level;
  end
  // The receive word is loaded only on a transfer, so its value after reset is undefined.
  always_ff @(posedge mclk) begin
    if (events.rx_load) begin
      rx_data <= events.rx_word;
    end
  end
  // ==========================================================================
  // Interrupt
  logic multibuf;
  assign multibuf = control[`USFC_B_CTL_MULTIBUF];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_enable & `USFC_IRQ_SOURCES)
             | (irq_enable[`USFC_B_RXNE] & status[`USFC_B_OVERRUN])
             | (multibuf & irq_enable[`USFC_B_ERR_IE]
                & (status[`USFC_B_OVERRUN] | status[`USFC_B_NOISE]
                   | status[`USFC_B_FRAMING]));
    end
  end
  // ==========================================================================
  // Read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !acc) begin
      case (avs_address)
        `USFC_OFS_LINE_STATUS: avs_readdata <= status;
        `USFC_OFS_RECEIVE_DATA: avs_readdata <= {{(32 - DATA_W){1'b0}}, rx_data};
        `USFC_OFS_IRQ_ENABLE: avs_readdata <= irq_enable;
        `USFC_OFS_CONTROL: avs_readdata <= control;
        `USFC_OFS_FLAG_CLEAR: avs_readdata <= 32'h0000_0000;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================================
  // Checks
  a_cts_toggle_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    (cts_q != clear_to_send_pin) |=> status[`USFC_B_CTS]) else $error("cts flag missed");
  a_tbe_write_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_data_write && !events.tx_load && !cmd[`USFC_B_CMD_TXFLUSH]) |=> !status[`USFC_B_TBE])
    else $error("tbe not cleared");
  a_tc_needs_tbe: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(status[`USFC_B_TC]) |-> $past(status[`USFC_B_TBE])) else $error("tc without tbe");
  a_rxne_read_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_read && !events.rx_load) |=> !status[`USFC_B_RXNE]) else $error("rxne kept");
  a_idle_rearm: assert property (@(posedge mclk) disable iff (!rst_n)
    (!idle_armed && !events.rx_load) |=> !$rose(status[`USFC_B_IDLE]))
    else $error("idle set twice");
  a_overrun_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    (events.rx_load && status[`USFC_B_RXNE]) |=> status[`USFC_B_OVERRUN])
    else $error("overrun missed");
  a_framing_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    events.sc_retry_exhausted |=> status[`USFC_B_FRAMING]) else $error("framing missed");
  a_parity_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (clr[`USFC_B_PARITY] && !events.parity) |=> !status[`USFC_B_PARITY])
    else $error("parity not cleared");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    (status[`USFC_B_TC] && irq_enable[`USFC_B_TC]) |=> irq) else $error("irq missing");
  a_reduced_lin: assert property (@(posedge mclk) disable iff (!rst_n)
    REDUCED |-> !status[`USFC_B_LIN]) else $error("lin flag in reduced");
  a_lin_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (clr[`USFC_B_LIN] && !events.lin_break) |=> !status[`USFC_B_LIN])
    else $error("lin flag not cleared");
  a_rxne_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    events.rx_load |=> status[`USFC_B_RXNE])
    else $error("rxne not set");
  a_noise_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    events.noise |=> status[`USFC_B_NOISE])
    else $error("noise flag missed");
  a_err_irq_routed: assert property (@(posedge mclk) disable iff (!rst_n)
    (multibuf && irq_enable[`USFC_B_ERR_IE] && status[`USFC_B_NOISE]) |=> irq)
    else $error("error irq missing");
  a_wake_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (clr[`USFC_B_WAKE] && !events.wakeup) |=> !status[`USFC_B_WAKE])
    else $error("wakeup not cleared");
  a_rx_word_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    events.rx_load |=> (rx_data == $past(events.rx_word)))
    else $error("receive word lost");
  a_clear_reads_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_read && !acc && hit(avs_address, `USFC_OFS_FLAG_CLEAR)) |=> (avs_readdata == 0))
    else $error("clear register not zero");
endmodule

//--- usfc_status_tb.sv
// Self-checking testbench of the status flag clear logic.
`timescale 1ns/100ps
`include "usfc_defs.svh"
module usfc_status_tb;
  logic mclk, arst_n, avs_read, avs_write, avs_waitrequest, irq, tx_data_write;
  logic clear_to_send_pin;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [8:0] tx_data;
  logic [2:0] control_bits;
  usfc_pkg::usfc_event_s events, ev;
  int n_fail, n_compared, k;
  int evp[9] = '{9, 7, 6, 5, 4, 3, 2, 1, 0};
  int stb[9] = '{8, 2, 1, 0, 1, 20, 17, 12, 11};
  // Byte enables stay full: every access is a whole word.
  usfc_status u_usfc_status (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clear_to_send_pin(clear_to_send_pin), .events(events), .tx_data_write(tx_data_write),
    .tx_data(tx_data), .control_bits(control_bits), .irq(irq));
  usfc_remote u_usfc_remote (.mclk(mclk), .events(events),
    .clear_to_send_pin(clear_to_send_pin));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================================================
  // Shared tasks
  task end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // The request stands until waitrequest is seen low; a spare edge follows the release.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge mclk);
    for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++) @(posedge mclk);
    if (i == 20) begin
      n_fail++;
      end_sim();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task st(input int b, input logic e);
    bus(1'b0, `USFC_OFS_LINE_STATUS, 32'h0);
    chk(q[b], e);
  endtask
  task clr(input int b);
    bus(1'b1, `USFC_OFS_FLAG_CLEAR, 32'h1 << b);
  endtask
  task irq_is(input logic e);
    @(posedge mclk);
    chk(irq, e);
  endtask
  // ==========================================================================
  // Scenarios
  task t_reset;
    bus(1'b0, `USFC_OFS_LINE_STATUS, 32'h0);
    chk(q, `USFC_STATUS_RESET);
    bus(1'b0, `USFC_OFS_FLAG_CLEAR, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h00, 32'hFFFFFFFF);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    $display("done reset");
  endtask
  task t_errs;
    for (k = 0; k < 9; k++) begin
      ev = usfc_pkg::usfc_event_s'(22'h1 << evp[k]);
      u_usfc_remote.send(ev);
      st(stb[k], 1'b1);
      bus(1'b1, `USFC_OFS_FLAG_CLEAR, ~(32'h1 << stb[k]));
      st(stb[k], 1'b1);
      clr(stb[k]);
      st(stb[k], 1'b0);
    end
    $display("done flags");
  endtask
  task t_cts;
    u_usfc_remote.toggle_cts();
    st(9, 1'b1);
    bus(1'b1, `USFC_OFS_IRQ_ENABLE, 32'h200);
    irq_is(1'b1);
    bus(1'b1, `USFC_OFS_IRQ_ENABLE, 32'h0);
    irq_is(1'b0);
    clr(9);
    st(9, 1'b0);
    $display("done cts");
  endtask
  task t_rx;
    bus(1'b1, `USFC_OFS_CONTROL, 32'h6);
    chk(control_bits, 3'h6);
    ev = '0;
    ev.rx_load = 1'b1;
    ev.rx_word = 9'h1A5;
    u_usfc_remote.send(ev);
    st(5, 1'b1);
    bus(1'b0, `USFC_OFS_RECEIVE_DATA, 32'h0);
    chk(q[8:0], 9'h1A5);
    st(5, 1'b0);
    ev = '0;
    ev.idle_line = 1'b1;
    u_usfc_remote.send(ev);
    st(4, 1'b1);
    clr(4);
    u_usfc_remote.send(ev);
    st(4, 1'b0);
    ev = '0;
    ev.rx_load = 1'b1;
    u_usfc_remote.send(ev);
    u_usfc_remote.send(ev);
    st(3, 1'b1);
    bus(1'b1, `USFC_OFS_IRQ_ENABLE, 32'h20);
    bus(1'b0, `USFC_OFS_RECEIVE_DATA, 32'h0);
    irq_is(1'b1);
    clr(3);
    irq_is(1'b0);
    ev = '0;
    ev.idle_line = 1'b1;
    u_usfc_remote.send(ev);
    st(4, 1'b1);
    clr(4);
    ev = '0;
    ev.rx_load = 1'b1;
    u_usfc_remote.send(ev);
    bus(1'b1, `USFC_OFS_COMMAND, 32'h2);
    st(5, 1'b0);
    bus(1'b1, `USFC_OFS_IRQ_ENABLE, 32'h0);
    $display("done receive");
  endtask
  task t_tx;
    bus(1'b1, `USFC_OFS_TRANSMIT_DATA, 32'h155);
    chk(tx_data, 9'h155);
    st(7, 1'b0);
    ev = '0;
    ev.tx_frame_done = 1'b1;
    u_usfc_remote.send(ev);
    st(6, 1'b0);
    ev = '0;
    ev.tx_load = 1'b1;
    u_usfc_remote.send(ev);
    st(7, 1'b1);
    ev = '0;
    ev.tx_frame_done = 1'b1;
    u_usfc_remote.send(ev);
    st(6, 1'b1);
    clr(6);
    st(6, 1'b0);
    bus(1'b1, `USFC_OFS_TRANSMIT_DATA, 32'h0AA);
    bus(1'b1, `USFC_OFS_COMMAND, 32'h1);
    st(7, 1'b1);
    $display("done transmit");
  endtask
  task t_mb;
    bus(1'b1, `USFC_OFS_CONTROL, 32'h1);
    bus(1'b1, `USFC_OFS_IRQ_ENABLE, 32'h400);
    ev = '0;
    ev.noise = 1'b1;
    u_usfc_remote.send(ev);
    irq_is(1'b1);
    bus(1'b1, `USFC_OFS_CONTROL, 32'h0);
    irq_is(1'b0);
    clr(2);
    $display("done multibuffer");
  endtask
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_errs;
    t_cts;
    t_rx;
    t_tx;
    t_mb;
    end_sim;
  end
endmodule
